/* hdl/motor_stop_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_stop_sequencer
    import stop_seq_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run_terminal,
    input wire logic enable_terminal,
    input wire logic fast_stop_terminal,
    input wire logic freewheel_terminal,
    input wire stop_cfg_t cfg,
    input wire logic signed [15:0] speed_setpoint,
    input wire logic signed [15:0] speed_feedback,
    input wire logic signed [15:0] current_demand,
    input wire logic [15:0] normal_current_limit,
    input wire logic [15:0] profile_current_limit,
    output drive_status_t status,
    output logic signed [15:0] speed_demand,
    output logic signed [15:0] current_cmd,
    output logic [15:0] current_limit
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic signed [15:0] step_toward_zero(
        input logic signed [15:0] value,
        input logic [15:0] step
    );
        logic [15:0] mag;
        mag = value[15] ? 16'(-value) : 16'(value);
        if (mag <= step)
            step_toward_zero = LEVEL_ZERO;
        else if (value[15])
            step_toward_zero = 16'(value + $signed({1'b0, step[14:0]}));
        else
            step_toward_zero = 16'(value - $signed({1'b0, step[14:0]}));
    endfunction

    function automatic logic [15:0] ramp_step(input logic [15:0] tenths);
        ramp_step = (tenths == TIME_RESET) ? SPEED_FULL : 16'(SPEED_FULL / tenths);
    endfunction

    // ------------------------------------------------------------
    // tick and decode
    // ------------------------------------------------------------
    localparam int TW = $clog2(TICK_LEN + 1);
    logic [TW-1:0] tick_cnt_reg;
    logic tick_reg;
    stop_state_t state_reg, state_next;
    logic fast_hold_reg, fast_hold_next;
    logic run_armed_reg;
    logic [15:0] hold_cnt_reg, timeout_cnt_reg;
    logic [15:0] fb_mag;
    wire logic at_stop_speed;
    wire logic stops_clear;
    wire logic hold_done;
    wire logic normal_timeout_hit;
    wire logic fast_timeout_hit;
    wire logic in_stop;
    wire logic high_thresh;
    assign fb_mag = speed_feedback[15] ? 16'(-speed_feedback) : 16'(speed_feedback);
    assign at_stop_speed = fb_mag <= cfg.stop_threshold;
    assign stops_clear = fast_stop_terminal && freewheel_terminal;
    assign hold_done = hold_cnt_reg >= cfg.hold_time;
    assign normal_timeout_hit = timeout_cnt_reg >= cfg.normal_timeout;
    assign fast_timeout_hit = timeout_cnt_reg >= cfg.fast_stop_timeout;
    assign in_stop = state_reg == ST_NORMAL_STOP || state_reg == ST_FAST_STOP;
    assign high_thresh = cfg.stop_threshold > LOW_THRESH;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || tick_cnt_reg == TW'(TICK_LEN - 1))
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        tick_reg <= rst_n && tick_cnt_reg == TW'(TICK_LEN - 1);
    end

    // ------------------------------------------------------------
    // stop state machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        fast_hold_next = fast_hold_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (run_terminal && run_armed_reg && stops_clear && enable_terminal)
                    state_next = ST_RUN;
            end
            ST_RUN:
            begin
                if (!fast_stop_terminal)
                    state_next = ST_FAST_STOP;
                else if (!run_terminal)
                    state_next = ST_NORMAL_STOP;
            end
            ST_NORMAL_STOP:
            begin
                if (!fast_stop_terminal)
                    state_next = ST_FAST_STOP;
                else if (run_terminal)
                    state_next = ST_RUN;
                else if (at_stop_speed)
                begin
                    state_next = ST_HOLD;
                    fast_hold_next = 1'b0;
                end
                else if (normal_timeout_hit)
                    state_next = ST_IDLE;
            end
            ST_FAST_STOP:
            begin
                if (fast_stop_terminal)
                    state_next = run_terminal ? ST_RUN : ST_NORMAL_STOP;
                else if (at_stop_speed)
                begin
                    state_next = ST_HOLD;
                    fast_hold_next = 1'b1;
                end
                else if (fast_timeout_hit)
                    state_next = ST_IDLE;
            end
            ST_HOLD:
            begin
                if (hold_done || !enable_terminal)
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_IDLE;
        endcase
        if (!freewheel_terminal)
            state_next = ST_IDLE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            fast_hold_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            fast_hold_reg <= fast_hold_next;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || state_reg != ST_IDLE)
            run_armed_reg <= 1'b0;
        else if (!run_terminal)
            run_armed_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // stop timers, counted in ticks
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || state_reg != ST_HOLD)
            hold_cnt_reg <= TIME_RESET;
        else if (tick_reg && !hold_done)
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || !in_stop || state_next != state_reg)
            timeout_cnt_reg <= TIME_RESET;
        else if (tick_reg && timeout_cnt_reg != 16'hFFFF)
            timeout_cnt_reg <= timeout_cnt_reg + 1'b1;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic drive_on;
    assign drive_on = enable_terminal && (state_reg == ST_RUN || in_stop
        || (state_reg == ST_HOLD && !fast_hold_reg && !high_thresh));

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            status <= '0;
            speed_demand <= LEVEL_ZERO;
            current_limit <= '0;
        end
        else
        begin
            status.contactor <= state_next != ST_IDLE;
            status.drive_enable <= drive_on && state_next != ST_IDLE;
            status.loops_reset <= !enable_terminal || !drive_on;
            status.fast_stop_active <= state_reg == ST_FAST_STOP;
            if (state_reg == ST_RUN)
                speed_demand <= speed_setpoint;
            else if (state_reg == ST_FAST_STOP && tick_reg)
                speed_demand <= step_toward_zero(speed_demand,
                    ramp_step(cfg.fast_stop_ramp_time));
            else if (state_reg == ST_NORMAL_STOP && tick_reg)
                speed_demand <= step_toward_zero(speed_demand,
                    ramp_step(cfg.normal_ramp_time));
            else if (state_reg == ST_IDLE)
                speed_demand <= LEVEL_ZERO;
            if (state_reg == ST_FAST_STOP)
                current_limit <= cfg.fast_stop_current_ceiling < profile_current_limit
                    ? cfg.fast_stop_current_ceiling : profile_current_limit;
            else
                current_limit <= normal_current_limit < profile_current_limit
                    ? normal_current_limit : profile_current_limit;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            current_cmd <= LEVEL_ZERO;
        else if (status.drive_enable)
            current_cmd <= current_demand;
        else if (cfg.current_quench_rate == TIME_RESET)
            current_cmd <= LEVEL_ZERO;
        else if (tick_reg)
            current_cmd <= step_toward_zero(current_cmd, cfg.current_quench_rate);
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_freewheel;
        @(posedge ref_clk) disable iff (!rst_n)
        !freewheel_terminal |=> !status.contactor && !status.drive_enable;
    endproperty
    a_freewheel: assert property (p_freewheel) else $error("freewheel not honoured");

    property p_enable;
        @(posedge ref_clk) disable iff (!rst_n)
        !enable_terminal |=> status.loops_reset && !status.drive_enable;
    endproperty
    a_enable: assert property (p_enable) else $error("loops not reset");

    property p_run_blocked;
        @(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_IDLE && !stops_clear |=> state_reg == ST_IDLE;
    endproperty
    a_run_blocked: assert property (p_run_blocked) else $error("run accepted in stop");

    property p_ceiling;
        @(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_FAST_STOP |=> current_limit <= $past(cfg.fast_stop_current_ceiling);
    endproperty
    a_ceiling: assert property (p_ceiling) else $error("fast stop ceiling exceeded");

    property p_hold_contactor;
        @(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_HOLD && !hold_done && enable_terminal && freewheel_terminal
            |=> status.contactor;
    endproperty
    a_hold_contactor: assert property (p_hold_contactor) else $error("contactor dropped early");

    property p_hold_enter;
        @(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_NORMAL_STOP && at_stop_speed && fast_stop_terminal
            && !run_terminal && freewheel_terminal |=> state_reg == ST_HOLD;
    endproperty
    a_hold_enter: assert property (p_hold_enter) else $error("hold not started");

    property p_high_thresh;
        @(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_HOLD && high_thresh |=> !status.drive_enable;
    endproperty
    a_high_thresh: assert property (p_high_thresh) else $error("drive on in hold");

    property p_fast_timeout;
        @(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_FAST_STOP && fast_timeout_hit && !at_stop_speed
            && !fast_stop_terminal |=> state_reg == ST_IDLE ##1 !status.contactor;
    endproperty
    a_fast_timeout: assert property (p_fast_timeout) else $error("fast timeout ignored");

    property p_normal_timeout;
        @(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_NORMAL_STOP && normal_timeout_hit && !at_stop_speed
            && stops_clear && !run_terminal |=> state_reg == ST_IDLE;
    endproperty
    a_normal_timeout: assert property (p_normal_timeout) else $error("normal timeout ignored");

    property p_timer_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        state_reg == ST_RUN |=> timeout_cnt_reg == TIME_RESET;
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");
endmodule
`default_nettype wire

/* hdl/stop_seq_pkg.sv */
// What this block does
// - hold contactor for hold time after zero
// - fast stop ramps full speed in ramp time
// - fast stop uses own capped current ceiling
// - stop threshold starts hold in both stops
// - freewheel stop disables and opens contactor now
// - enable removed holds loops in reset
// - run ignored while any stop input active
// - run removed ramps down then releases
// - threshold above 0.25 disables during hold
// - normal stop timeout releases contactor, disables
package stop_seq_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 250_000_000;
    localparam int TICK_TIME_MS = 100;
    localparam int TICK_CYCLES = TICK_TIME_MS * (CLK_HZ / 1000);
    // ------------------------------------------------------------
    // scaling, hundredths of a percent
    // ------------------------------------------------------------
    localparam logic [15:0] SPEED_FULL = 16'h2710;
    localparam logic [15:0] LOW_THRESH = 16'h0019;
    localparam logic [15:0] TIME_RESET = 16'h0000;
    localparam logic signed [15:0] LEVEL_ZERO = 16'sh0000;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] hold_time;
        logic [15:0] normal_ramp_time;
        logic [15:0] normal_timeout;
        logic [15:0] fast_stop_ramp_time;
        logic [15:0] fast_stop_timeout;
        logic [15:0] fast_stop_current_ceiling;
        logic [15:0] current_quench_rate;
        logic [15:0] stop_threshold;
    } stop_cfg_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_NORMAL_STOP,
        ST_FAST_STOP,
        ST_HOLD
    } stop_state_t;
    typedef struct packed {
        logic contactor;
        logic drive_enable;
        logic loops_reset;
        logic fast_stop_active;
    } drive_status_t;
endpackage

/* verif/motor_load.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_load
    import stop_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic signed [15:0] speed_demand,
    output logic signed [15:0] speed_feedback
);
    // ------------------------------------------------------------
    // load speed: follows demand one cycle late, stalled load stays at full
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            speed_feedback <= LEVEL_ZERO;
        else if (stall)
            speed_feedback <= $signed(SPEED_FULL);
        else
            speed_feedback <= speed_demand;
    end
endmodule
`default_nettype wire

/* verif/motor_stop_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_stop_sequencer_tb
    import stop_seq_pkg::*;
;
    localparam int T = 10;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic run_terminal = 1'b0;
    logic enable_terminal = 1'b1;
    logic fast_stop_terminal = 1'b1;
    logic freewheel_terminal = 1'b1;
    logic stall = 1'b0;
    stop_cfg_t cfg = '{16'h0003, 16'h0004, 16'h0032, 16'h0002, 16'h0032, 16'h3A98, 16'h012C,
        16'h00C8};
    logic signed [15:0] speed_setpoint = 16'sh2710;
    logic signed [15:0] current_demand = 16'sh03E8;
    logic [15:0] normal_current_limit = 16'h2710;
    logic [15:0] profile_current_limit = 16'h4650;
    logic signed [15:0] speed_feedback;
    drive_status_t status;
    logic signed [15:0] speed_demand;
    logic signed [15:0] current_cmd;
    logic [15:0] current_limit;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_cyc = 0;
    int n;
    // ------------------------------------------------------------
    // clock, design and load
    // ------------------------------------------------------------
    always #2 ref_clk = ~ref_clk;
    motor_stop_sequencer #(.TICK_LEN(T)) dut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run_terminal(run_terminal),
        .enable_terminal(enable_terminal),
        .fast_stop_terminal(fast_stop_terminal),
        .freewheel_terminal(freewheel_terminal),
        .cfg(cfg),
        .speed_setpoint(speed_setpoint),
        .speed_feedback(speed_feedback),
        .current_demand(current_demand),
        .normal_current_limit(normal_current_limit),
        .profile_current_limit(profile_current_limit),
        .status(status),
        .speed_demand(speed_demand),
        .current_cmd(current_cmd),
        .current_limit(current_limit)
    );
    motor_load load (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .stall(stall),
        .speed_demand(speed_demand),
        .speed_feedback(speed_feedback)
    );
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        n_compared++;
        if (seen !== expected)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic win(input int got, input int lo, input int hi);
        check(16'(got >= lo && got <= hi), 16'h0001);
    endtask
    // counts cycles until contactor (sel 0) or drive enable (sel 1) is low
    task automatic wait_low(input int sel, output int cnt);
        cnt = 0;
        while (cnt < 2000 && ((sel == 0) ? status.contactor : status.drive_enable) !== 1'b0)
        begin
            @(negedge ref_clk);
            cnt++;
        end
    endtask
    task automatic start_run;
        run_terminal = 1'b0;
        cyc(2);
        run_terminal = 1'b1;
        cyc(3);
        check(16'(status.contactor), 16'h0001);
    endtask
    always @(posedge ref_clk)
    begin
        n_cyc++;
        if (n_cyc == 10000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        cyc(12);
        rst_n = 1'b1;
        fast_stop_terminal = 1'b0;
        cyc(2);
        run_terminal = 1'b1;
        cyc(5);
        check(16'(status.contactor), 16'h0000);
        fast_stop_terminal = 1'b1;
        start_run();
        check(current_limit, 16'h2710);
        // normal stop, threshold above the low limit
        run_terminal = 1'b0;
        wait_low(1, n);
        win(n, 3 * T, 4 * T + 5);
        check(speed_demand, 16'h0000);
        check(16'(status.contactor), 16'h0001);
        wait_low(0, n);
        win(n, 2 * T, 3 * T + 5);
        // normal stop, threshold below the low limit
        cfg.stop_threshold = 16'h000A;
        start_run();
        run_terminal = 1'b0;
        wait_low(1, n);
        check(16'(status.contactor), 16'h0000);
        win(n, 5 * T, 7 * T + 5);
        cfg.stop_threshold = 16'h00C8;
        // normal stop timeout with a stalled load
        cfg.normal_timeout = 16'h0003;
        start_run();
        stall = 1'b1;
        run_terminal = 1'b0;
        wait_low(0, n);
        win(n, 2 * T, 3 * T + 5);
        stall = 1'b0;
        cfg.normal_timeout = 16'h0032;
        // fast stop
        start_run();
        fast_stop_terminal = 1'b0;
        cyc(2);
        check(16'(status.fast_stop_active), 16'h0001);
        check(current_limit, 16'h3A98);
        wait_low(1, n);
        check(speed_demand, 16'h0000);
        win(n, T - 2, 2 * T + 3);
        check(16'(status.contactor), 16'h0001);
        wait_low(0, n);
        win(n, 2 * T, 3 * T + 5);
        fast_stop_terminal = 1'b1;
        // fast stop timeout, cleared by a withdrawal
        cfg.fast_stop_timeout = 16'h0004;
        profile_current_limit = 16'h2EE0;
        start_run();
        stall = 1'b1;
        fast_stop_terminal = 1'b0;
        cyc(25);
        check(16'(status.contactor), 16'h0001);
        check(current_limit, 16'h2EE0);
        fast_stop_terminal = 1'b1;
        cyc(3);
        fast_stop_terminal = 1'b0;
        cyc(28);
        check(16'(status.contactor), 16'h0001);
        wait_low(0, n);
        win(n, 1, 20);
        fast_stop_terminal = 1'b1;
        stall = 1'b0;
        profile_current_limit = 16'h4650;
        // fast stop withdrawn with run low, then enable cuts the hold short
        start_run();
        fast_stop_terminal = 1'b0;
        cyc(2);
        run_terminal = 1'b0;
        fast_stop_terminal = 1'b1;
        cyc(2);
        check(16'({status.contactor, status.fast_stop_active}), 16'h0002);
        wait_low(1, n);
        enable_terminal = 1'b0;
        cyc(2);
        check(16'(status.contactor), 16'h0000);
        enable_terminal = 1'b1;
        // freewheel stop and current quench
        start_run();
        freewheel_terminal = 1'b0;
        cyc(1);
        check(16'({status.contactor, status.drive_enable}), 16'h0000);
        check(16'(current_cmd > 0), 16'h0001);
        cyc(T);
        check(current_cmd, 16'h02BC);
        cyc(4 * T);
        check(current_cmd, 16'h0000);
        run_terminal = 1'b0;
        cyc(2);
        run_terminal = 1'b1;
        cyc(5);
        check(16'(status.contactor), 16'h0000);
        freewheel_terminal = 1'b1;
        start_run();
        // enable removed and restored
        enable_terminal = 1'b0;
        cyc(2);
        check(16'(status.loops_reset), 16'h0001);
        enable_terminal = 1'b1;
        cyc(2);
        check(16'(status.loops_reset), 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
